// [design/bopd_pkg.sv]
package bopd_pkg;

    // ------------------------------------------------------------------
    // opcode fields, upper six, seven or eight bits of the instruction word, or the whole word
    // ------------------------------------------------------------------
    localparam logic [5:0] OP6_ADD_WITH_CARRY = 6'b0010_00;
    localparam logic [5:0] OP6_DEC_SKIP_ZERO = 6'b0010_11;
    localparam logic [5:0] OP6_DEC_SKIP_NONZERO = 6'b0100_11;
    localparam logic [5:0] OP6_INC_SKIP_ZERO = 6'b0011_11;
    localparam logic [5:0] OP6_INC_SKIP_NONZERO = 6'b0100_10;
    localparam logic [5:0] OP6_ROTATE_LEFT_CARRY = 6'b0011_01;
    localparam logic [5:0] OP6_ROTATE_RIGHT_PLAIN = 6'b0100_00;
    localparam logic [5:0] OP6_SUB_W_FROM_REG = 6'b0101_10;
    localparam logic [5:0] OP6_SUB_REG_FROM_W = 6'b0101_01;
    localparam logic [5:0] OP6_OR_REGISTER = 6'b0001_00;
    localparam logic [6:0] OP7_CMP_EQUAL = 7'b0110_001;
    localparam logic [6:0] OP7_CMP_GREATER = 7'b0110_010;
    localparam logic [6:0] OP7_CMP_LESS = 7'b0110_000;
    localparam logic [6:0] OP7_MULTIPLY = 7'b0000_001;
    localparam logic [7:0] OP8_OR_LITERAL = 8'h09;
    localparam logic [15:0] OPW_POP = 16'h0006;
    localparam logic [15:0] OPW_PUSH = 16'h0005;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam logic [7:0] WORKING_REGISTER_RESET = 8'h00;
    localparam logic [20:0] PC_RESET = 21'h00_0000;
    localparam logic [20:0] PC_STEP = 21'h00_0002;
    localparam logic [7:0] TIMER_ZERO_ADDR = 8'hD6;
    localparam logic [7:0] PORT_ADDR_LO = 8'h80;
    localparam logic [7:0] PORT_ADDR_HI = 8'h88;
    localparam int STACK_DEPTH = 31;
    localparam int STACK_AW = 5;

    // four quarter-cycles of one instruction cycle
    typedef enum logic [1:0] {
        Q_DECODE,
        Q_READ,
        Q_PROCESS,
        Q_WRITE
    } bopd_quarter_e;

    // arithmetic status flags
    typedef struct packed {
        logic negative;
        logic overflow;
        logic zero;
        logic digit_carry;
        logic carry;
    } bopd_flags_s;

    // file-register access request
    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } bopd_file_req_s;

endpackage : bopd_pkg

// [design/bopd_stack.sv]
module bopd_stack
    import bopd_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // stack operations
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [20:0] push_data_i,
    // top entry and pointer
    output logic [20:0] top_o,
    output logic [STACK_AW-1:0] ptr_o
);

    logic [20:0] mem_q [STACK_DEPTH];
    logic [STACK_AW-1:0] ptr_q;
    logic [20:0] top_q;

    // ------------------------------------------------------------------
    // pointer and storage; overflow/underflow saturate, no reset traps here
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ptr_q <= '0;
        end else if (push_i && ptr_q != STACK_AW'(STACK_DEPTH)) begin
            ptr_q <= ptr_q + 1'b1;
        end else if (pop_i && ptr_q != '0) begin
            ptr_q <= ptr_q - 1'b1;
        end
    end

    // entries written on push; old top stays one level down
    always_ff @(posedge mclk_i) begin
        if (push_i && ptr_q != STACK_AW'(STACK_DEPTH)) begin
            mem_q[ptr_q] <= push_data_i;
        end
    end

    // registered read of the new top
    wire [STACK_AW-1:0] next_ptr = push_i && ptr_q != STACK_AW'(STACK_DEPTH) ? ptr_q + 1'b1
        : pop_i && ptr_q != '0 ? ptr_q - 1'b1 : ptr_q;
    // entry just under the new pointer is the one that becomes visible after a pop
    wire [20:0] below_top = next_ptr != '0 ? mem_q[next_ptr - 1'b1] : '0;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            top_q <= '0;
        end else if (push_i && ptr_q != STACK_AW'(STACK_DEPTH)) begin
            top_q <= push_data_i;
        end else if (pop_i) begin
            top_q <= below_top;
        end
    end

    assign top_o = top_q;
    assign ptr_o = ptr_q;

endmodule : bopd_stack

// [design/bopd_decoder.sv]
// Function
// - add-with-carry adds W, carry and f; updates C, DC, Z, OV, N.
// - compares equal/greater/less skip next word on success, flags untouched.
// - decrement-skip-zero writes destination, skips if result zero, no flags.
// - decrement-skip-nonzero writes destination, skips if result nonzero, no flags.
// - increment-skip-zero writes destination, skips if result zero, no flags.
// - increment-skip-nonzero writes destination, skips if result nonzero, no flags.
// - multiply W by f in one cycle, no flags changed.
// - rotate left through carry; updates C, Z, N.
// - rotate right without carry; updates Z and N only.
// - f minus W minus borrow; all five arithmetic flags.
// - W minus f minus borrow; all five arithmetic flags.
// - OR W with f; updates N and Z only.
// - OR literal into W in one cycle; updates N and Z.
// - port read-modify-write uses pin levels, not the output latch; done only for access-bank addresses (access bit 0).
// - write to timer-zero clears its prescaler when assigned.
// - changed PC or true test costs a second cycle run as no-op.
// - second word of a two-word instruction runs as no-op.
// - push is one cycle, no flags, old top moves one level down.
// - push writes PC plus two as the new top in second quarter.
// - a started table write continues until it terminates.
module bopd_decoder
    import bopd_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // program memory
    input wire logic [15:0] instr_i,
    output logic [20:0] pc_o,
    // file register data
    input wire logic [7:0] file_rdata_i,
    input wire logic [7:0] port_pins_i,
    output bopd_file_req_s file_req_o,
    // configuration
    input wire logic [3:0] bank_select_register_i,
    input wire logic prescaler_on_timer_i,
    input wire logic table_write_busy_i,
    // state out
    output logic [7:0] working_register_o,
    output bopd_flags_s flags_o,
    output logic [15:0] product_o,
    output logic prescaler_clear_o,
    output logic [20:0] stack_top_entry_o,
    output bopd_quarter_e quarter_o,
    output logic table_write_hold_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    bopd_quarter_e q_q;
    logic [15:0] ir_q;
    logic [20:0] pc_q;
    logic [7:0] w_q;
    logic [7:0] opnd_q;
    logic [8:0] res_q;
    bopd_flags_s flags_q;
    logic [15:0] prod_q;
    logic nop_next_q;
    logic nop_cur_q;
    logic presc_q;
    bopd_file_req_s req_q;
    logic [20:0] stack_top;
    logic hold_q;
    logic [7:0] pins_s1_q;
    logic [7:0] pins_s2_q;

    // pins pass two flops before use
    // only the second flop feeds logic; the first may still be settling
    always_ff @(posedge mclk_i) begin
        pins_s1_q <= port_pins_i;
        pins_s2_q <= pins_s1_q;
    end

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire [5:0] op6 = ir_q[15:10];
    wire [6:0] op7 = ir_q[15:9];
    wire is_adc = op6 == OP6_ADD_WITH_CARRY;
    wire is_dsz = op6 == OP6_DEC_SKIP_ZERO;
    wire is_dsnz = op6 == OP6_DEC_SKIP_NONZERO;
    wire is_isz = op6 == OP6_INC_SKIP_ZERO;
    wire is_isnz = op6 == OP6_INC_SKIP_NONZERO;
    wire is_rlc = op6 == OP6_ROTATE_LEFT_CARRY;
    wire is_rrn = op6 == OP6_ROTATE_RIGHT_PLAIN;
    wire is_swb = op6 == OP6_SUB_W_FROM_REG;
    wire is_sfwb = op6 == OP6_SUB_REG_FROM_W;
    wire is_ior = op6 == OP6_OR_REGISTER;
    wire is_ceq = op7 == OP7_CMP_EQUAL;
    wire is_cgt = op7 == OP7_CMP_GREATER;
    wire is_clt = op7 == OP7_CMP_LESS;
    wire is_mul = op7 == OP7_MULTIPLY;
    wire is_iorl = ir_q[15:8] == OP8_OR_LITERAL;
    wire is_pop = ir_q == OPW_POP;
    wire is_push = ir_q == OPW_PUSH;
    wire is_cmp = is_ceq | is_cgt | is_clt;
    wire is_fop = is_adc | is_dsz | is_dsnz | is_isz | is_isnz | is_rlc | is_rrn | is_swb
        | is_sfwb | is_ior;
    // access bit 0 picks the access bank, 1 the bank select register
    wire [11:0] f_addr = ir_q[ACCESS_BIT] ? {bank_select_register_i, ir_q[7:0]}
        : {{4{ir_q[7]}}, ir_q[7:0]};
    wire dest_file = ir_q[DEST_BIT];
    wire is_port = f_addr[7:0] >= PORT_ADDR_LO && f_addr[7:0] < PORT_ADDR_HI
        && !ir_q[ACCESS_BIT];
    // port operand comes from synced pin levels
    wire [7:0] opnd_src = is_port ? pins_s2_q : file_rdata_i;
    // address of the incoming word, so the read address already stands in the read quarter
    wire [11:0] f_addr_in = instr_i[ACCESS_BIT] ? {bank_select_register_i, instr_i[7:0]}
        : {{4{instr_i[7]}}, instr_i[7:0]};

    // ------------------------------------------------------------------
    // data processing
    // ------------------------------------------------------------------
    wire cin = flags_q.carry;
    wire [8:0] sum_adc = {1'b0, w_q} + {1'b0, opnd_q} + {8'h00, cin};
    wire [4:0] dc_adc = {1'b0, w_q[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, cin};
    // borrow is the inverted carry: carry set means no borrow
    wire [8:0] dif_swb = {1'b0, opnd_q} - {1'b0, w_q} - {8'h00, ~cin};
    wire [4:0] dc_swb = {1'b0, opnd_q[3:0]} - {1'b0, w_q[3:0]} - {4'h0, ~cin};
    wire [8:0] dif_sfwb = {1'b0, w_q} - {1'b0, opnd_q} - {8'h00, ~cin};
    wire [4:0] dc_sfwb = {1'b0, w_q[3:0]} - {1'b0, opnd_q[3:0]} - {4'h0, ~cin};
    // counting ops never touch the flags; they feed the skip decision and the write-back
    wire [7:0] dec_v = opnd_q - 8'h01;
    wire [7:0] inc_v = opnd_q + 8'h01;
    wire [7:0] or_lit = w_q | ir_q[7:0];

    logic [8:0] alu;
    logic [4:0] alu_dc;
    always_comb begin
        alu = {1'b0, opnd_q};
        alu_dc = 5'h00;
        if (is_adc) begin
            alu = sum_adc;
            alu_dc = dc_adc;
        end else if (is_swb) begin
            alu = {~dif_swb[8], dif_swb[7:0]};
            alu_dc = {~dc_swb[4], dc_swb[3:0]};
        end else if (is_sfwb) begin
            alu = {~dif_sfwb[8], dif_sfwb[7:0]};
            alu_dc = {~dc_sfwb[4], dc_sfwb[3:0]};
        end else if (is_dsz || is_dsnz) begin
            alu = {1'b0, dec_v};
        end else if (is_isz || is_isnz) begin
            alu = {1'b0, inc_v};
        end else if (is_rlc) begin
            alu = {opnd_q[7], opnd_q[6:0], cin};
        end else if (is_rrn) begin
            alu = {1'b0, opnd_q[0], opnd_q[7:1]};
        end else if (is_ior) begin
            alu = {1'b0, w_q | opnd_q};
        end else if (is_iorl) begin
            alu = {1'b0, or_lit};
        end
    end

    // overflow for signed add or subtract
    wire ov_add = (w_q[7] == opnd_q[7]) && (sum_adc[7] != w_q[7]);
    wire ov_swb = (opnd_q[7] != w_q[7]) && (dif_swb[7] != opnd_q[7]);
    wire ov_sfwb = (w_q[7] != opnd_q[7]) && (dif_sfwb[7] != w_q[7]);
    // zero and negative look at the registered result, not the live alu
    wire res_zero = res_q[7:0] == 8'h00;

    // skip conditions
    wire skip = (is_ceq && opnd_q == w_q) || (is_cgt && opnd_q > w_q)
        || (is_clt && opnd_q < w_q) || (is_dsz && dec_v == 8'h00)
        || (is_dsnz && dec_v != 8'h00) || (is_isz && inc_v == 8'h00)
        || (is_isnz && inc_v != 8'h00);

    // ------------------------------------------------------------------
    // quarter sequencer: decode, read, process, write back
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q_q <= Q_DECODE;
        end else begin
            case (q_q)
                Q_DECODE: q_q <= Q_READ;
                Q_READ: q_q <= Q_PROCESS;
                Q_PROCESS: q_q <= Q_WRITE;
                default: q_q <= Q_DECODE;
            endcase
        end
    end

    // fetch and program counter; a busy table write stalls the core
    // limitation: a stall refetches the word at the held pc, keep busy off over side effects
    wire adv = q_q == Q_WRITE && !table_write_busy_i;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ir_q <= 16'h0000;
            pc_q <= PC_RESET;
            nop_cur_q <= 1'b1;
            hold_q <= 1'b0;
        end else begin
            hold_q <= table_write_busy_i;
            if (q_q == Q_DECODE) begin
                ir_q <= instr_i;
                nop_cur_q <= nop_next_q; // skipped word runs as a no-op
            end
            if (adv) begin
                pc_q <= pc_q + PC_STEP;
            end
        end
    end

    // operand latched in read quarter, result in process quarter
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            opnd_q <= 8'h00;
            res_q <= 9'h000;
            prod_q <= 16'h0000;
        end else if (q_q == Q_READ) begin
            opnd_q <= opnd_src;
        end else if (q_q == Q_PROCESS) begin
            res_q <= alu;
            if (is_mul && !nop_cur_q) begin
                prod_q <= w_q * opnd_q; // no flags touched
            end
        end
    end

    // write back: working register, flags, file request, skip
    wire exec = q_q == Q_WRITE && !nop_cur_q;
    wire to_w = exec && ((is_fop && !dest_file) || is_iorl);
    wire to_f = exec && is_fop && dest_file;
    // only these three touch carry, digit carry and overflow together
    wire arith = is_adc | is_swb | is_sfwb;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            w_q <= WORKING_REGISTER_RESET;
            flags_q <= '0;
            req_q <= '0;
            nop_next_q <= 1'b0;
            presc_q <= 1'b0;
        end else begin
            req_q.we <= to_f;
            req_q.addr <= q_q == Q_DECODE ? f_addr_in : f_addr;
            req_q.wdata <= res_q[7:0];
            presc_q <= to_f && f_addr[7:0] == TIMER_ZERO_ADDR && prescaler_on_timer_i;
            if (to_w) begin
                w_q <= res_q[7:0];
            end
            if (exec && arith) begin
                flags_q.carry <= res_q[8];
                flags_q.digit_carry <= alu_dc[4];
                flags_q.overflow <= is_adc ? ov_add : is_swb ? ov_swb : ov_sfwb;
                flags_q.zero <= res_zero;
                flags_q.negative <= res_q[7];
            end else if (exec && is_rlc) begin
                flags_q.carry <= res_q[8];
                flags_q.zero <= res_zero;
                flags_q.negative <= res_q[7];
            end else if (exec && (is_rrn || is_ior || is_iorl)) begin
                flags_q.zero <= res_zero;
                flags_q.negative <= res_q[7];
            end
            // a true skip turns the next word into a no-op slot instead of adding a cycle
            if (q_q == Q_WRITE) begin
                nop_next_q <= exec && (skip || is_cmp && skip);
            end
        end
    end

    // return stack: push in read quarter two, pop in process
    // the new top reaches stack_top_entry_o two edges later through top_q
    bopd_stack u_stack (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .push_i(q_q == Q_READ && is_push && !nop_cur_q),
        .pop_i(q_q == Q_PROCESS && is_pop && !nop_cur_q),
        .push_data_i(pc_q + PC_STEP),
        .top_o(stack_top),
        .ptr_o()
    );

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    logic [20:0] top_q;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            top_q <= '0;
        end else begin
            top_q <= stack_top;
        end
    end

    // quarter_o is the live sequencer flop, so memory answers in the quarter the core samples
    assign pc_o = pc_q;
    assign file_req_o = req_q;
    assign working_register_o = w_q;
    assign flags_o = flags_q;
    assign product_o = prod_q;
    assign prescaler_clear_o = presc_q;
    assign stack_top_entry_o = top_q;
    assign quarter_o = q_q;
    assign table_write_hold_o = hold_q;

endmodule : bopd_decoder

// [tb/bopd_decoder_sva.sv]
module bopd_decoder_sva
    import bopd_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // inputs watched
    input wire logic [15:0] instr_i,
    input wire logic prescaler_on_timer_i,
    input wire logic table_write_busy_i,
    // outputs watched
    input wire logic [20:0] pc_o,
    input wire bopd_file_req_s file_req_o,
    input wire logic [7:0] working_register_o,
    input wire bopd_flags_s flags_o,
    input wire logic [15:0] product_o,
    input wire logic prescaler_clear_o,
    input wire logic [20:0] stack_top_entry_o,
    input wire bopd_quarter_e quarter_o,
    input wire logic table_write_hold_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // sequencing checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // a pending table write freezes the pc, so stalled cycles are left out
    wire logic run_w = !table_write_busy_i && !table_write_hold_o;
    AST_QUARTER_WALK: assert property (
        run_w && quarter_o == Q_DECODE |=> quarter_o == Q_READ)
        else $error("quarter did not move from decode to read");
    AST_PC_STEP: assert property (
        run_w && quarter_o == Q_WRITE |=> pc_o == $past(pc_o) + PC_STEP)
        else $error("pc did not step by two after write-back");
    AST_PC_HOLD: assert property (
        quarter_o != Q_WRITE |=> $stable(pc_o))
        else $error("pc moved outside write-back");
    AST_WB_QUARTER: assert property (
        quarter_o != Q_WRITE |=> $stable(working_register_o) && $stable(flags_o))
        else $error("working register or flags moved outside write-back");
    AST_WE_PULSE: assert property (
        file_req_o.we |=> !file_req_o.we)
        else $error("file write strobe longer than one cycle");
    AST_PRESCALER: assert property (
        prescaler_clear_o |-> $past(prescaler_on_timer_i) ##1 !prescaler_clear_o)
        else $error("prescaler clear without assignment or too long");
    AST_HOLD_COPY: assert property (
        table_write_hold_o == $past(table_write_busy_i))
        else $error("table write hold does not follow busy");
    AST_PC_STALL: assert property (
        table_write_busy_i && table_write_hold_o |=> $stable(pc_o))
        else $error("pc advanced during table write");
    AST_MUL_FLAGS: assert property (
        $changed(product_o) |-> $stable(flags_o))
        else $error("multiply touched the flags");
    AST_PUSH_TOP: assert property (
        run_w && quarter_o == Q_DECODE && instr_i == OPW_PUSH
        |-> ##[3:5] stack_top_entry_o == pc_o)
        else $error("push did not place pc plus two on top");
    AST_STACK_FLAGS: assert property (
        run_w && quarter_o == Q_DECODE && (instr_i == OPW_POP || instr_i == OPW_PUSH)
        |-> ##4 $stable(flags_o) && $stable(working_register_o))
        else $error("stack op changed flags or working register");
endmodule : bopd_decoder_sva

bind bopd_decoder bopd_decoder_sva u_sva (.mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr_i),
    .prescaler_on_timer_i(prescaler_on_timer_i), .table_write_busy_i(table_write_busy_i),
    .pc_o(pc_o), .file_req_o(file_req_o), .working_register_o(working_register_o),
    .flags_o(flags_o), .product_o(product_o), .prescaler_clear_o(prescaler_clear_o),
    .stack_top_entry_o(stack_top_entry_o), .quarter_o(quarter_o),
    .table_write_hold_o(table_write_hold_o));

// [tb/bopd_prog_mem.sv]
module bopd_prog_mem
    import bopd_pkg::*;
(
    // clock and phase
    input wire logic mclk_i,
    input wire bopd_quarter_e quarter_i,
    // program side
    input wire logic [20:0] pc_i,
    output logic [15:0] instr_o,
    // file register side
    input wire bopd_file_req_s file_req_i,
    output logic [7:0] rdata_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] pmem [0:31];
    logic [7:0] dmem [0:255];
    wire logic [15:0] word_w = (pc_i[20:6] == 15'h0000) ? pmem[pc_i[5:1]] : 16'h0000;
    wire logic [7:0] byte_w = dmem[file_req_i.addr[7:0]];
    // words and bytes are only valid in their sampling quarter; stale data is inverted
    assign instr_o = (quarter_i == Q_DECODE) ? word_w : ~word_w;
    assign rdata_o = (quarter_i == Q_READ) ? byte_w : ~byte_w;
    // write strobe lands on the next edge
    always @(posedge mclk_i) begin
        if (file_req_i.we === 1'b1) begin
            dmem[file_req_i.addr[7:0]] <= file_req_i.wdata;
        end
    end
endmodule : bopd_prog_mem

// [tb/bopd_decoder_tb_top.sv]
module bopd_decoder_tb_top;
    import bopd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] instr;
    logic [20:0] pc;
    logic [7:0] rdata;
    logic [7:0] pins = 8'h00;
    bopd_file_req_s freq;
    logic [3:0] bank_select_register = 4'h3;
    logic psa = 1'b0;
    logic busy = 1'b0;
    logic [7:0] w;
    bopd_flags_s fl;
    logic [15:0] prod;
    logic pclr;
    logic [20:0] top;
    bopd_quarter_e qtr;
    logic hold;
    logic [11:0] last_addr = 12'h000;
    int n_errors = 0;
    int checks_done = 0;
    int pclr_seen = 0;

    always #2 mclk_i = ~mclk_i;

    bopd_decoder DUT (.mclk_i(mclk_i), .rst_i(rst_i), .instr_i(instr), .pc_o(pc),
        .file_rdata_i(rdata), .port_pins_i(pins), .file_req_o(freq),
        .bank_select_register_i(bank_select_register), .prescaler_on_timer_i(psa), .table_write_busy_i(busy),
        .working_register_o(w), .flags_o(fl), .product_o(prod), .prescaler_clear_o(pclr),
        .stack_top_entry_o(top), .quarter_o(qtr), .table_write_hold_o(hold));
    bopd_prog_mem u_mem (.mclk_i(mclk_i), .quarter_i(qtr), .pc_i(pc), .instr_o(instr),
        .file_req_i(freq), .rdata_o(rdata));

    // watch write addresses and prescaler clear pulses
    always @(posedge mclk_i) begin
        if (freq.we === 1'b1) begin
            last_addr <= freq.addr;
        end
        if (pclr === 1'b1) begin
            pclr_seen++;
        end
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic chkf(input bopd_flags_s e, input bopd_flags_s g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] flags expected %b seen %b", e, g);
        end
    endtask : chkf
    // word 0 stays 0000, which matches no opcode, since the first cycle after reset executes it
    task automatic boot(input logic [15:0] p [$]);
        for (int i = 0; i < 32; i++) begin
            u_mem.pmem[i] = 16'h0000;
        end
        foreach (p[i]) begin
            u_mem.pmem[i + 1] = p[i];
        end
        rst_i = 1'b1;
        step(3);
        rst_i = 1'b0;
        step(4 * (p.size() + 3));
    endtask : boot
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic s_or();
        u_mem.dmem[8'h10] = 8'h40;
        boot('{16'h099A, 16'h0935, 16'h1310});
        chk("w", 21'h00_00BF, 21'(w));
        chk("f10", 21'h00_00FF, 21'(u_mem.dmem[8'h10]));
        chk("waddr", 21'h00_0310, 21'(last_addr));
        chkf(5'b10000, fl);
    endtask : s_or
    task automatic s_add_mul();
        u_mem.dmem[8'h20] = 8'h01;
        u_mem.dmem[8'h21] = 8'h03;
        boot('{16'h097F, 16'h2120, 16'h0321});
        chk("w", 21'h00_0080, 21'(w));
        chkf(5'b11010, fl);
        chk("product", 21'h00_0180, 21'(prod));
    endtask : s_add_mul
    task automatic s_sub();
        u_mem.dmem[8'h30] = 8'h05;
        boot('{16'h0901, 16'h5B30, 16'h5530});
        chk("f30", 21'h00_0003, 21'(u_mem.dmem[8'h30]));
        chk("w", 21'h00_00FE, 21'(w));
        chkf(5'b10000, fl);
    endtask : s_sub
    task automatic s_rot();
        u_mem.dmem[8'h30] = 8'h05;
        u_mem.dmem[8'h40] = 8'h81;
        u_mem.dmem[8'h41] = 8'h01;
        boot('{16'h0901, 16'h5B30, 16'h3540, 16'h4341});
        chk("w", 21'h00_0003, 21'(w));
        chk("f41", 21'h00_0080, 21'(u_mem.dmem[8'h41]));
        chkf(5'b10011, fl);
    endtask : s_rot
    // each compare or counting op is followed by a word that sets bit 7 of w
    task automatic s_skip();
        logic [15:0] op [7] = '{16'h6350, 16'h6550, 16'h6150, 16'h2F50, 16'h4F50,
            16'h3F50, 16'h4B50};
        logic [7:0] fv [7] = '{8'h05, 8'h06, 8'h06, 8'h01, 8'h01, 8'hFF, 8'h10};
        logic [7:0] fx [7] = '{8'h05, 8'h06, 8'h06, 8'h00, 8'h00, 8'h00, 8'h11};
        logic [6:0] sk = 7'b1101011;
        for (int i = 0; i < 7; i++) begin
            u_mem.dmem[8'h50] = fv[i];
            boot('{16'h0905, op[i], 16'h0980});
            chk("w", sk[i] ? 21'h00_0005 : 21'h00_0085, 21'(w));
            chk("f50", 21'(fx[i]), 21'(u_mem.dmem[8'h50]));
            chkf(sk[i] ? 5'b00000 : 5'b10000, fl);
        end
    endtask : s_skip
    task automatic s_stack();
        logic [20:0] p0;
        boot('{16'h0005, 16'h0005, 16'h0006});
        chk("top", 21'h00_0004, top);
        chkf(5'b00000, fl);
        busy = 1'b1;
        step(2);
        p0 = pc;
        step(8);
        chk("pc", p0, pc);
        chk("hold", 21'h00_0001, 21'(hold));
        busy = 1'b0;
        step(4);
    endtask : s_stack
    task automatic s_port();
        pins = 8'h5A;
        psa = 1'b1;
        u_mem.dmem[8'h80] = 8'h0F;
        u_mem.dmem[8'hD6] = 8'h00;
        boot('{16'h0901, 16'h1280, 16'h12D6});
        chk("f80", 21'h00_005B, 21'(u_mem.dmem[8'h80]));
        chk("pclr", 21'h00_0001, 21'(pclr_seen));
        psa = 1'b0;
    endtask : s_port
    // ----------------------------------------------------------------
    // run control
    // ----------------------------------------------------------------
    task automatic end_sim();
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    // whole run is a few hundred cycles; over ten times that means a hang
    initial begin
        #20000;
        n_errors++;
        end_sim();
    end
    initial begin
        s_or();
        s_add_mul();
        s_sub();
        s_rot();
        s_skip();
        s_stack();
        s_port();
        end_sim();
    end
endmodule : bopd_decoder_tb_top
